// ---- hw/spf_pin_ctrl.sv ----
// Pin-function control of a serial peripheral interface: decides per pin
// whether the shift engine or the general-purpose port owns it, and which way.
// Assumes an APB master on sys_clk, a shift engine on sys_clk, and pins that
// are asynchronous to sys_clk (the serial clock included).
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
`include "spf_regs.svh"

// Function
// - Disabled: all pins to port logic
// - Clock pin input as slave, output as master
// - Two-wire: MOSI out master, in slave
// - Single-wire master: MOSI shared, direction bit
// - Single-wire slave: MOSI back to port
// - Two-wire: MISO in master, out slave
// - Single-wire slave: MISO shared, direction bit
// - Single-wire master: MISO back to port
// - Slave: select is active-low input
// - Master without fault check: select to port
// - Master with fault check: select by bit
module spf_pin_ctrl
    import spf_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic                sys_clk,  // System clock, 20 MHz
    input  wire logic                nrst,     // Asynchronous reset, active low
    input  wire logic                ce,       // Clock enable, freezes all state
    input  wire logic                psel,     // APB select
    input  wire logic                penable,  // APB access phase
    input  wire logic                pwrite,   // APB direction
    input  wire logic [ADDR_W-1:0]   paddr,    // APB byte address
    input  wire logic [31:0]         pwdata,   // APB write data
    output logic      [31:0]         prdata,   // APB read data
    output logic                     pready,   // APB ready
    output logic                     pslverr,  // APB error, unmapped address
    input  wire logic [3:0]          pin_in,   // Pin levels: sck, mosi, miso, sel
    output logic      [3:0]          pin_out,  // Pin output values
    output logic      [3:0]          pin_oe,   // Pin output enables, high drives
    input  wire logic [3:0]          gpio_out, // Port logic output values
    input  wire logic [3:0]          gpio_oe,  // Port logic output enables
    output logic      [3:0]          gpio_in,  // Synchronised pin levels for port
    output logic      [3:0]          spi_owns, // Pin owned by the interface
    input  wire spf_eng_out_t        eng_out,  // Engine drive values
    output spf_eng_in_t              eng_in,   // Sampled inputs for engine
    output spf_ctrl_t                ctrl      // Control bits for engine
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (ADDR_W < 3 || ADDR_W > 32)
        begin : g_bad_addr
            $error("spf_pin_ctrl: ADDR_W must lie in 3..32");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    spf_ctrl_t          ctrl_r;
    spf_ctrl_t          ctrl_nxt;
    logic               fault_r;
    logic               fault_nxt;
    logic [31:0]        rdata_r;
    logic [31:0]        rdata_nxt;
    logic [3:0]         sync1_r;
    logic [3:0]         sync1_nxt;
    logic [3:0]         sync2_r;
    logic [3:0]         sync2_nxt;
    logic               sck_prev_r;
    logic               sck_prev_nxt;
    logic [3:0]         pout_r;
    logic [3:0]         pout_nxt;
    logic [3:0]         poe_r;
    logic [3:0]         poe_nxt;
    logic [3:0]         owns_r;
    logic [3:0]         owns_nxt;
    spf_eng_in_t        ein_r;
    spf_eng_in_t        ein_nxt;
    spf_role_t          role [`SPF_NPINS];
    logic [3:0]         eng_val;
    logic [7:0]         role_bits;
    logic               wr_acc;
    logic               setup;
    logic               hit_ctrl;
    logic               hit_stat;
    logic               fault_evt;

    // ****************************************
    // APB slave
    // ****************************************
    assign hit_ctrl = paddr == ADDR_W'(`SPF_CTRL_OFS);
    assign hit_stat = paddr == ADDR_W'(`SPF_STAT_OFS);
    assign setup    = ce && psel && !penable;
    assign wr_acc   = ce && psel && penable && pwrite;

    // Read data is captured in the setup cycle so it leaves a flop; a frozen
    // clock enable also holds off the handshake, but a read whose setup cycle is frozen completes with stale data.
    assign pready  = ce;
    assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
    assign prdata  = rdata_r;

    always_comb
    begin
        role_bits = '0;
        for (int i = 0; i < `SPF_NPINS; i++)
        begin
            role_bits[2*i +: 2] = role[i];
        end
    end

    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        fault_nxt = fault_r;
        rdata_nxt = rdata_r;
        if (wr_acc && hit_ctrl)
        begin
            ctrl_nxt = pwdata[`SPF_CTRL_W-1:0];
        end
        // Write one clears the fault flag, but a new fault wins
        if (wr_acc && hit_stat && pwdata[`SPF_STAT_FAULT])
        begin
            fault_nxt = 1'b0;
        end
        if (fault_evt)
        begin
            fault_nxt = 1'b1;
        end
        if (setup)
        begin
            rdata_nxt = '0;
            if (hit_ctrl)
            begin
                rdata_nxt[`SPF_CTRL_W-1:0] = ctrl_r;
            end
            else if (hit_stat)
            begin
                rdata_nxt[`SPF_STAT_ROLE_LSB +: 8] = role_bits;
                rdata_nxt[`SPF_STAT_FAULT]         = fault_r;
                rdata_nxt[`SPF_STAT_LVL_LSB +: 4]  = sync2_r;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r  <= `SPF_CTRL_RST;
            fault_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            fault_r <= fault_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign ctrl = ctrl_r;

    // ****************************************
    // Pin roles
    // ****************************************
    always_comb
    begin
        for (int i = 0; i < `SPF_NPINS; i++)
        begin
            role[i] = SPF_ROLE_GPIO;
        end
        if (ctrl_r.interface_enable)
        begin
            role[`SPF_PIN_SCK] = ctrl_r.master ? SPF_ROLE_OUT : SPF_ROLE_IN;
            if (!ctrl_r.single_wire_select)
            begin
                role[`SPF_PIN_MOSI] = ctrl_r.master ? SPF_ROLE_OUT : SPF_ROLE_IN;
                role[`SPF_PIN_MISO] = ctrl_r.master ? SPF_ROLE_IN : SPF_ROLE_OUT;
            end
            else if (ctrl_r.master)
            begin
                role[`SPF_PIN_MOSI] = ctrl_r.bidir_output_enable ? SPF_ROLE_OUT
                                                                  : SPF_ROLE_IN;
                role[`SPF_PIN_MISO] = SPF_ROLE_GPIO;
            end
            else
            begin
                role[`SPF_PIN_MOSI] = SPF_ROLE_GPIO;
                role[`SPF_PIN_MISO] = ctrl_r.bidir_output_enable ? SPF_ROLE_OUT
                                                                  : SPF_ROLE_IN;
            end
            if (!ctrl_r.master)
            begin
                role[`SPF_PIN_SEL] = SPF_ROLE_IN;
            end
            else if (!ctrl_r.mode_fault_enable)
            begin
                role[`SPF_PIN_SEL] = SPF_ROLE_GPIO;
            end
            else
            begin
                role[`SPF_PIN_SEL] = ctrl_r.select_output_enable ? SPF_ROLE_OUT
                                                                 : SPF_ROLE_IN;
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    assign eng_val[`SPF_PIN_SCK]  = eng_out.sck;
    assign eng_val[`SPF_PIN_MOSI] = eng_out.data;
    assign eng_val[`SPF_PIN_MISO] = eng_out.data;
    assign eng_val[`SPF_PIN_SEL]  = eng_out.sel_n;

    genvar gp;
    generate
        for (gp = 0; gp < `SPF_NPINS; gp++)
        begin : g_pin
            always_comb
            begin
                pout_nxt[gp] = pout_r[gp];
                poe_nxt[gp]  = poe_r[gp];
                owns_nxt[gp] = owns_r[gp];
                if (ce)
                begin
                    case (role[gp])
                        SPF_ROLE_OUT:
                        begin
                            pout_nxt[gp] = eng_val[gp];
                            poe_nxt[gp]  = 1'b1;
                            owns_nxt[gp] = 1'b1;
                        end
                        SPF_ROLE_IN:
                        begin
                            pout_nxt[gp] = 1'b0;
                            poe_nxt[gp]  = 1'b0;
                            owns_nxt[gp] = 1'b1;
                        end
                        default:
                        begin
                            pout_nxt[gp] = gpio_out[gp];
                            poe_nxt[gp]  = gpio_oe[gp];
                            owns_nxt[gp] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************
    // Input sampling
    // ****************************************
    // Pins, the serial clock among them, are asynchronous: two flops first.
    // The slow link clock (400 ns) is oversampled here, so edges come late by
    // two to three system cycles; the engine must allow for that skew.
    always_comb
    begin
        sync1_nxt    = ce ? pin_in : sync1_r;
        sync2_nxt    = ce ? sync1_r : sync2_r;
        sck_prev_nxt = sck_prev_r;
        ein_nxt      = ein_r;
        fault_evt    = 1'b0;
        if (ce)
        begin
            ein_nxt = '{sck: 1'b0, sck_rise: 1'b0, sck_fall: 1'b0,
                        data: 1'b0, sel_n: 1'b1, mode_fault: 1'b0};
            // History follows the pin in every role, so a clock pin that was
            // driven high does not read as a fresh rise once it turns input
            sck_prev_nxt = sync2_r[`SPF_PIN_SCK];
            if (role[`SPF_PIN_SCK] == SPF_ROLE_IN)
            begin
                ein_nxt.sck      = sync2_r[`SPF_PIN_SCK];
                ein_nxt.sck_rise = sync2_r[`SPF_PIN_SCK] && !sck_prev_r;
                ein_nxt.sck_fall = !sync2_r[`SPF_PIN_SCK] && sck_prev_r;
            end
            if (role[`SPF_PIN_MOSI] == SPF_ROLE_IN)
            begin
                ein_nxt.data = sync2_r[`SPF_PIN_MOSI];
            end
            else if (role[`SPF_PIN_MISO] == SPF_ROLE_IN)
            begin
                ein_nxt.data = sync2_r[`SPF_PIN_MISO];
            end
            if (role[`SPF_PIN_SEL] == SPF_ROLE_IN)
            begin
                if (!ctrl_r.master)
                begin
                    ein_nxt.sel_n = sync2_r[`SPF_PIN_SEL];
                end
                else
                begin
                    // low level is a mode fault
                    ein_nxt.mode_fault = !sync2_r[`SPF_PIN_SEL];
                    fault_evt          = !sync2_r[`SPF_PIN_SEL];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            sck_prev_r <= 1'b0;
            ein_r      <= '{sck: 1'b0, sck_rise: 1'b0, sck_fall: 1'b0,
                            data: 1'b0, sel_n: 1'b1, mode_fault: 1'b0};
            pout_r     <= '0;
            poe_r      <= '0;
            owns_r     <= '0;
        end
        else
        begin
            sync1_r    <= sync1_nxt;
            sync2_r    <= sync2_nxt;
            sck_prev_r <= sck_prev_nxt;
            ein_r      <= ein_nxt;
            pout_r     <= pout_nxt;
            poe_r      <= poe_nxt;
            owns_r     <= owns_nxt;
        end
    end

    assign eng_in   = ein_r;
    assign pin_out  = pout_r;
    assign pin_oe   = poe_r;
    assign spi_owns = owns_r;
    assign gpio_in  = sync2_r;

endmodule

// ---- hw/spf_regs.svh ----
// Register offsets, field positions and reset values of the pin-function block.
// Assumes a 32-bit APB slave decoding byte addresses on aligned words.
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SPF_CTRL_OFS      12'h000
`define SPF_STAT_OFS      12'h004

// ****************************************
// Control register fields
// ****************************************
`define SPF_CTRL_W        6
`define SPF_CTRL_RST      6'h00

// ****************************************
// Status register fields
// ****************************************
`define SPF_STAT_ROLE_LSB 0
`define SPF_STAT_FAULT    8
`define SPF_STAT_LVL_LSB  9

// ****************************************
// Pin indexes
// ****************************************
`define SPF_PIN_SCK       0
`define SPF_PIN_MOSI      1
`define SPF_PIN_MISO      2
`define SPF_PIN_SEL       3
`define SPF_NPINS         4

`endif

// ---- hw/spf_pkg.sv ----
// Types shared by the pin-function block and its surroundings.
// Assumes the offsets and fields of spf_regs.svh.
package spf_pkg;

    typedef enum logic [1:0] {SPF_ROLE_GPIO, SPF_ROLE_IN, SPF_ROLE_OUT} spf_role_t;

    // Bit 0 is interface_enable, upward in declaration order reversed
    typedef struct packed {
        logic select_output_enable;
        logic mode_fault_enable;
        logic bidir_output_enable;
        logic single_wire_select;
        logic master;
        logic interface_enable;
    } spf_ctrl_t;

    // Values the shift engine wants on its pins
    typedef struct packed {
        logic sck;
        logic data;
        logic sel_n;
    } spf_eng_out_t;

    // Sampled pin values handed to the shift engine
    typedef struct packed {
        logic sck;
        logic sck_rise;
        logic sck_fall;
        logic data;
        logic sel_n;
        logic mode_fault;
    } spf_eng_in_t;

endpackage

// ---- testbench/spf_pin_ctrl_checker.sv ----
// Port-level checks of the pin-function block.
// Assumes spf_pkg and one clock domain; bound to every spf_pin_ctrl below.
`timescale 1ns/1ns

module spf_pin_ctrl_checker
    import spf_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              sys_clk,  // Clock
    input wire logic              nrst,     // Reset, active low
    input wire logic              ce,       // Clock enable
    input wire logic              psel,     // APB select
    input wire logic              penable,  // APB access
    input wire logic              pwrite,   // APB direction
    input wire logic [ADDR_W-1:0] paddr,    // APB address
    input wire logic [31:0]       pwdata,   // APB write data
    input wire logic [31:0]       prdata,   // APB read data
    input wire logic              pready,   // APB ready
    input wire logic              pslverr,  // APB error
    input wire logic [3:0]        pin_in,   // Pin levels
    input wire logic [3:0]        pin_out,  // Pin values
    input wire logic [3:0]        pin_oe,   // Pin enables
    input wire logic [3:0]        gpio_out, // Port values
    input wire logic [3:0]        gpio_oe,  // Port enables
    input wire logic [3:0]        gpio_in,  // Synced levels
    input wire logic [3:0]        spi_owns, // Ownership
    input wire spf_eng_out_t      eng_out,  // Engine drive
    input wire spf_eng_in_t       eng_in,   // Engine inputs
    input wire spf_ctrl_t         ctrl      // Control bits
);
    // ****************
    // Shorthands
    // ****************
    // All but sw include ce, since a frozen edge updates nothing
    wire logic on  = ce && ctrl.interface_enable;
    wire logic mst = on && ctrl.master;
    wire logic slv = on && !ctrl.master;
    wire logic sw  = ctrl.single_wire_select;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    release_all_a: assert property (
        ce && !ctrl.interface_enable |=> spi_owns == 4'h0 && pin_oe == $past(gpio_oe))
        else $error("pins kept while disabled");
    clock_dir_a: assert property (
        on ##1 on |-> spi_owns[0] && pin_oe[0] == $past(ctrl.master))
        else $error("clock pin direction wrong");
    master_shared_data_pin_dir_a: assert property (
        mst && sw |=> spi_owns[1] && pin_oe[1] == $past(ctrl.bidir_output_enable))
        else $error("shared master pin direction wrong");
    mosi_free_a: assert property (
        (slv && sw)[*2] |-> !spi_owns[1] && pin_oe[1] == $past(gpio_oe[1]))
        else $error("unused out pin kept");
    slave_shared_data_pin_dir_a: assert property (
        slv && sw |=> spi_owns[2] && pin_oe[2] == $past(ctrl.bidir_output_enable))
        else $error("shared slave pin direction wrong");
    miso_free_a: assert property (
        mst && sw |=> !spi_owns[2] && pin_out[2] == $past(gpio_out[2]))
        else $error("unused in pin kept");
    select_free_a: assert property (
        mst && !ctrl.mode_fault_enable |=> !spi_owns[3] && pin_oe[3] == $past(gpio_oe[3]))
        else $error("select pin kept");
    select_bit_a: assert property (
        mst && ctrl.mode_fault_enable |=> spi_owns[3] && pin_oe[3] == $past(ctrl[5]))
        else $error("select pin direction wrong");
endmodule

bind spf_pin_ctrl spf_pin_ctrl_checker #(.ADDR_W(ADDR_W)) spf_pin_ctrl_checker_i (
    .sys_clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .gpio_out, .gpio_oe, .gpio_in, .spi_owns,
    .eng_out, .eng_in, .ctrl
);

// ---- testbench/spf_far_device.sv ----
// Model of the serial device on the far side of the pins.
// Assumes pin order clock, out, in, select; sends 8'ha5 MSB first.
`timescale 1ns/1ns

module spf_far_device
(
    input  wire logic       sys_clk, // Clock for the float pattern
    input  wire logic       go,      // Rise starts one frame
    input  wire logic [3:0] pin_out, // Block pin values
    input  wire logic [3:0] pin_oe,  // Block pin enables
    output logic      [3:0] pin_in   // Resolved pin levels
);
    logic       sck_r = 1'h0;
    logic       sel_n_r = 1'h1;
    logic       dat_r = 1'h0;
    logic       busy = 1'h0;
    logic       flip = 1'h0;
    logic [7:0] pat;

    // Released data lines toggle so a stale value is never mistaken for data
    always @(posedge sys_clk)
        flip <= ~flip;

    always @(posedge go)
    begin
        #13;
        busy = 1'h1;
        sel_n_r = 1'h0;
        pat = 8'ha5;
        repeat (8)
        begin
            dat_r = pat[7];
            pat = pat << 1;
            #200 sck_r = 1'h1;
            #200 sck_r = 1'h0;
        end
        #200 sel_n_r = 1'h1;
        busy = 1'h0;
    end

    assign pin_in[0] = pin_oe[0] ? pin_out[0] : sck_r;
    assign pin_in[1] = pin_oe[1] ? pin_out[1] : (busy ? dat_r : flip);
    assign pin_in[2] = pin_oe[2] ? pin_out[2] : (busy ? dat_r : flip);
    // Select line has a pull-up
    assign pin_in[3] = pin_oe[3] ? pin_out[3] : sel_n_r;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the pin-function block over APB and its pins.
// Assumes spf_pkg, the checker bind and the far device model.
`timescale 1ns/1ns

module testbench
    import spf_pkg::*;
;
    logic         sys_clk, nrst, ce, psel, penable, pwrite, go, err, low;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         pready, pslverr;
    logic [3:0]   pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in, spi_owns;
    logic [3:0]   eo, oe, ov, ev;
    logic [7:0]   rr, sh;
    logic [5:0]   c;
    spf_eng_out_t eng_out;
    spf_eng_in_t  eng_in;
    spf_ctrl_t    ctrl;
    int           fails, total_checks, cnt;

    spf_pin_ctrl #(.ADDR_W(12)) spf_pin_ctrl_i (
        .sys_clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .gpio_out, .gpio_oe, .gpio_in,
        .spi_owns, .eng_out, .eng_in, .ctrl
    );
    spf_far_device spf_far_device_i (.sys_clk, .go, .pin_out, .pin_oe, .pin_in);

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************
    // Tasks
    // ****************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer; an edge always passes before the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'h1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1)
        begin
            fails++;
            complete_run();
        end
    endtask

    // Runs one far-side frame and records what the engine side saw
    task automatic frame();
        cnt = 0;
        sh = 8'h00;
        low = 1'h0;
        @(posedge sys_clk);
        go <= 1'h1;
        repeat (100)
        begin
            @(negedge sys_clk);
            if (eng_in.sck_rise === 1'h1)
            begin
                cnt++;
                sh = {sh[6:0], eng_in.data};
            end
            if (eng_in.sel_n === 1'h0)
                low = 1'h1;
        end
        @(posedge sys_clk);
        go <= 1'h0;
    endtask

    // Roles per pin, two bits each: 0 port, 1 input, 2 output
    function automatic logic [7:0] roles(input logic [5:0] k);
        spf_ctrl_t  f;
        logic [1:0] r0, r1, r2, r3;
        f = spf_ctrl_t'(k);
        r0 = f.master ? 2'h2 : 2'h1;
        r1 = !f.single_wire_select ? r0 : (!f.master ? 2'h0 : {f[3], !f[3]});
        r2 = !f.single_wire_select ? {!f.master, f.master} : (f.master ? 2'h0 : {f[3], !f[3]});
        r3 = !f.master ? 2'h1 : (!f.mode_fault_enable ? 2'h0 : {f[5], !f[5]});
        return f.interface_enable ? {r3, r2, r1, r0} : 8'h00;
    endfunction

    // ****************
    // Sequence
    // ****************
    initial
    begin
        {nrst, psel, penable, pwrite, go, paddr, pwdata} = '0;
        {gpio_out, gpio_oe, eng_out, fails, total_checks} = '0;
        ce = 1'h1;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'h1;
        for (int i = 0; i < 64; i++)
        begin
            c = i[5:0];
            @(posedge sys_clk);
            gpio_out <= ~c[3:0];
            gpio_oe <= c[5:2] ^ 4'h5;
            eng_out <= spf_eng_out_t'(c[2:0]);
            apb(1'h1, 12'h000, 32'(c));
            @(posedge sys_clk);
            @(negedge sys_clk);
            rr = roles(c);
            ev = {eng_out.sel_n, eng_out.data, eng_out.data, eng_out.sck};
            for (int p = 0; p < 4; p++)
            begin
                eo[p] = rr[2*p+:2] != 2'h0;
                oe[p] = rr[2*p+:2] == 2'h2 || (rr[2*p+:2] == 2'h0 && gpio_oe[p]);
                ov[p] = rr[2*p+:2] == 2'h2 ? ev[p] : (rr[2*p+:2] == 2'h0 && gpio_out[p]);
            end
            check("owner", 32'(eo), 32'(spi_owns));
            check("enable", 32'(oe), 32'(pin_oe));
            check("value", 32'(ov), 32'(pin_out));
            apb(1'h0, 12'h004, 32'h0);
            check("roles", 32'(rr), 32'(rd[7:0]));
            check("ctrl out", 32'(c), 32'(ctrl));
            // Clock idles low and select is pulled up unless a driver owns them
            check("levels", 32'({oe[3] ? ov[3] : 1'b1, 2'b00, oe[0] & ov[0]}),
                  32'(gpio_in & 4'h9));
        end
        apb(1'h1, 12'h000, 32'h01);
        frame();
        check("rises", 32'h8, 32'(cnt));
        check("bits", 32'ha5, 32'(sh));
        check("select", 32'h1, 32'(low));
        apb(1'h1, 12'h000, 32'h13);
        apb(1'h1, 12'h004, 32'h100);
        frame();
        apb(1'h0, 12'h004, 32'h0);
        check("fault", 32'h1, 32'(rd[8]));
        apb(1'h1, 12'h004, 32'h100);
        apb(1'h0, 12'h004, 32'h0);
        check("fault clear", 32'h0, 32'(rd[8]));
        apb(1'h1, 12'h00c, 32'h3f);
        check("slverr", 32'h1, 32'(err));
        apb(1'h0, 12'h000, 32'h0);
        check("ctrl", 32'h13, rd);
        // Frozen clock enable: new engine values must not reach the pins
        @(posedge sys_clk);
        ce <= 1'h0;
        eng_out <= '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check("frozen", 32'h3, 32'(pin_out));
        check("stall", 32'h0, 32'(pready));
        @(posedge sys_clk);
        ce <= 1'h1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("thawed", 32'h0, 32'(pin_out));
        complete_run();
    end
endmodule
